/* verilog/pcic_map.vh */
// Constant map of the packet coding and integrity chain.
// Assumes byte addresses on an APB bus with 32-bit data words.
`ifndef PCIC_MAP_VH
`define PCIC_MAP_VH
// Register byte addresses.
`define PCIC_ADDR_MOD_LO   8'h00
`define PCIC_ADDR_MOD_HI   8'h04
`define PCIC_ADDR_CHANNEL_FILTER_CFG    8'h08
`define PCIC_ADDR_CODING   8'h0c
`define PCIC_ADDR_STATUS   8'h10
// Field positions of packet_coding_cfg.
`define PCIC_SEL_MSB       2
`define PCIC_FEC_BIT       3
`define PCIC_WHIT_BIT      4
// Reset values.
`define PCIC_RST_MANT      8'h00
`define PCIC_RST_EXP       4'h0
`define PCIC_RST_CHANNEL_FILTER_CFG     8'h00
`define PCIC_RST_CODING    5'h10
// Data-rate generator: a 28-bit fraction accumulator.
`define PCIC_RATE_FRAC     28
// Channel filter reference clock in Hz.
`define PCIC_CHF_REF_HZ    26000000
// Checksum polynomials, as printed, for selector codes 1 to 4.
`define PCIC_POLY_8        8'h07
`define PCIC_POLY_16A      16'h8005
`define PCIC_POLY_16B      16'h1021
`define PCIC_POLY_24       24'h864cfb
// Convolutional generators 13 and 17 octal, tap order {input, newest .. oldest}.
`define PCIC_GEN_A         4'hb
`define PCIC_GEN_B         4'hf
// Whitening register: nine stages, all ones at packet start, tap at stage 5.
`define PCIC_LFSR_INIT     9'h1ff
`define PCIC_LFSR_TAP      5
// Viterbi decision depth in decoded bits.
`define PCIC_VIT_DEPTH     8
`endif

/* verilog/pcic_chain.v */
// Transmit and receive coding chain: checksum, whitening, convolutional code,
// 4x4 interleaver, padding and termination, plus the data-rate generator.
// Assumes a framer on one side, a modem on the other, and an APB master.
`timescale 1ns/1ns
`default_nettype none
`include "pcic_map.vh"
module pcic_chain #(
  parameter SOFT_W = 3,        // Soft sample width from the demodulator.
  parameter CLK_HZ = 25000000  // Digital clock rate.
) (
  input  wire              clk,
  input  wire              reset,
  input  wire              psel,
  input  wire              penable,
  input  wire              pwrite,
  input  wire [7:0]        paddr,
  input  wire [31:0]       pwdata,
  output reg  [31:0]       prdata,
  output wire              pready,
  output wire              pslverr,
  output reg               symbolTick,
  output wire [3:0]        chanFilterMantissa,
  output wire [3:0]        chanFilterExponent,
  output wire [8:0]        chanFilterScale,
  input  wire              txStart,
  input  wire [7:0]        txData,
  input  wire              txValid,
  input  wire              txLast,
  output wire              txReady,
  output reg               txBit,
  output reg               txBitValid,
  output wire              txBusy,
  output reg               txDone,
  input  wire              rxStart,
  input  wire [15:0]       rxLength,
  input  wire [SOFT_W-1:0] rxSoft,
  input  wire              rxSoftValid,
  output reg  [7:0]        rxData,
  output reg               rxDataValid,
  output reg               rxDone,
  output reg               rxCrcOk
);
  localparam PMW = SOFT_W + 4;                    // Path metric width.
  localparam [SOFT_W-1:0] SMAX = {SOFT_W{1'b1}};  // Most confident one.
  localparam [PMW-1:0] PM_FAR = {2'b01, {(PMW-2){1'b0}}};
  localparam [2:0] T_IDLE = 3'h0, T_DATA = 3'h1, T_CRC = 3'h2;
  localparam [2:0] T_PAD = 3'h3, T_TERM = 3'h4, T_DRAIN = 3'h5;

  // Software-visible configuration.
  reg [7:0] rateMant_reg;    // rate_mantissa.
  reg [3:0] rateExp_reg;     // rate_exponent.
  reg [7:0] chanFilter_reg;  // channel_filter_cfg: mantissa high, exponent low.
  reg [4:0] coding_reg;      // packet_coding_cfg.

  // Whitening of one byte, MSB first; returns {next state, byte}.
  function [16:0] whiten(input [7:0] d, input [8:0] s);
    integer i;
    reg [8:0] l;
    reg [7:0] o;
    begin
      l = s;
      for (i = 0; i < 8; i = i + 1) begin
        o[7-i] = d[7-i] ^ l[0];
        l = {l[0] ^ l[`PCIC_LFSR_TAP], l[8:1]};
      end
      whiten = {l, o};
    end
  endfunction

  // Checksum over one byte with a left-aligned register, no reflection.
  function [23:0] crcByte(input [23:0] c, input [7:0] d, input [23:0] p);
    integer i;
    reg [23:0] r;
    reg fb;
    begin
      r = c;
      for (i = 0; i < 8; i = i + 1) begin
        fb = r[23] ^ d[7-i];
        r = {r[22:0], 1'b0};
        if (fb) r = r ^ p;
      end
      crcByte = r;
    end
  endfunction

  // Encodes a byte and interleaves the 16 coded bits; returns {state, bits}.
  function [18:0] encode(input [7:0] b, input [2:0] s);
    integer i;
    integer k;
    reg [2:0] t;
    reg [15:0] c;
    reg [15:0] o;
    begin
      t = s;
      for (i = 0; i < 8; i = i + 1) begin
        c[2*i] = ^({b[7-i], t} & `PCIC_GEN_A);
        c[2*i+1] = ^({b[7-i], t} & `PCIC_GEN_B);
        t = {b[7-i], t[2:1]};
      end
      // Cell index is row*4+col; rows were filled, columns are read out.
      for (k = 0; k < 16; k = k + 1) o[15-k] = c[(k % 4) * 4 + k / 4];
      encode = {t, o};
    end
  endfunction

  // Branch metric of a soft pair against the bits a transition would send.
  function [PMW-1:0] branch(input [2:0] p, input u, input [SOFT_W-1:0] a,
                            input [SOFT_W-1:0] b);
    reg [SOFT_W-1:0] da;
    reg [SOFT_W-1:0] db;
    begin
      da = (^({u, p} & `PCIC_GEN_A)) ? SMAX - a : a;
      db = (^({u, p} & `PCIC_GEN_B)) ? SMAX - b : b;
      branch = {{(PMW-SOFT_W){1'b0}}, da} + {{(PMW-SOFT_W){1'b0}}, db};
    end
  endfunction

  // Polynomial, preset and length for a selector value.
  function [49:0] crcCfg(input [2:0] sel);
    begin
      case (sel)
        3'h1: crcCfg = {{`PCIC_POLY_8, 16'h0000}, 24'hff0000, 2'h1};
        3'h2: crcCfg = {{`PCIC_POLY_16A, 8'h00}, 24'hffff00, 2'h2};
        3'h3: crcCfg = {{`PCIC_POLY_16B, 8'h00}, 24'hffff00, 2'h2};
        3'h4: crcCfg = {`PCIC_POLY_24, 24'hffffff, 2'h3};
        default: crcCfg = 50'h0;
      endcase
    end
  endfunction

  // APB slave: zero-wait, read data captured in the setup cycle.
  wire apbWrite = psel & penable & pwrite;
  reg  mapped;
  reg [31:0] readMux;
  wire txActive;
  wire rxActive;
  reg  rxOk_reg;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  // Address decode and read multiplexer; unmapped reads return zero.
  always @* begin
    mapped = 1'b1;
    readMux = 32'h0;
    case (paddr)
      `PCIC_ADDR_MOD_LO: readMux = {24'h0, rateMant_reg};
      `PCIC_ADDR_MOD_HI: readMux = {28'h0, rateExp_reg};
      `PCIC_ADDR_CHANNEL_FILTER_CFG:  readMux = {24'h0, chanFilter_reg};
      `PCIC_ADDR_CODING: readMux = {27'h0, coding_reg};
      `PCIC_ADDR_STATUS: readMux = {29'h0, rxOk_reg, rxActive, txActive};
      default:           mapped = 1'b0;
    endcase
  end

  // Register writes; only mapped addresses take effect.
  always @(posedge clk) begin
    if (reset) begin
      rateMant_reg <= `PCIC_RST_MANT;
      rateExp_reg <= `PCIC_RST_EXP;
      chanFilter_reg <= `PCIC_RST_CHANNEL_FILTER_CFG;
      coding_reg <= `PCIC_RST_CODING;
      prdata <= 32'h0;
    end else begin
      if (psel & ~penable) prdata <= readMux;
      if (apbWrite) begin
        case (paddr)
          `PCIC_ADDR_MOD_LO: rateMant_reg <= pwdata[7:0];
          `PCIC_ADDR_MOD_HI: rateExp_reg <= pwdata[3:0];
          `PCIC_ADDR_CHANNEL_FILTER_CFG:  chanFilter_reg <= pwdata[7:0];
          `PCIC_ADDR_CODING: coding_reg <= pwdata[4:0];
          default: ;
        endcase
      end
    end
  end

  // Filter fields go to the analog-side filter; the scale factor, in 1/256
  // units, tells it how far the tabled bandwidths move with this clock.
  assign chanFilterMantissa = chanFilter_reg[7:4];
  assign chanFilterExponent = chanFilter_reg[3:0];
  // Worked out in 64 bits: the product overflows a 32-bit integer at usual clock rates.
  localparam [63:0] CHF_SCALE = (64'd256 * CLK_HZ) / `PCIC_CHF_REF_HZ;
  assign chanFilterScale = CHF_SCALE[8:0];

  // Rate generator: the carry out of a 28-bit accumulator is the tick.
  // The step never exceeds 2^24, so ticks stay at least 16 clocks apart.
  reg  [`PCIC_RATE_FRAC-1:0] rateAcc_reg;
  wire [23:0] rateStep = {15'h0000, 1'b1, rateMant_reg} << rateExp_reg;
  wire [`PCIC_RATE_FRAC:0] rateSum = {1'b0, rateAcc_reg} + {5'h00, rateStep};
  always @(posedge clk) begin
    if (reset) begin
      rateAcc_reg <= 28'h0;
      symbolTick <= 1'b0;
    end else begin
      rateAcc_reg <= rateSum[`PCIC_RATE_FRAC-1:0];
      symbolTick <= rateSum[`PCIC_RATE_FRAC];
    end
  end

  // Transmit side; configuration is frozen at packet start.
  reg [2:0]  tState_reg;
  reg        tFec_reg;
  reg        tWhit_reg;
  reg [49:0] tCfg_reg;      // Checksum polynomial, preset, length.
  reg [8:0]  tLfsr_reg;
  reg [23:0] tCrc_reg;
  reg [2:0]  tEnc_reg;      // Encoder memory.
  reg        tOdd_reg;      // Parity of bytes sent so far.
  reg [1:0]  tCrcIdx_reg;
  reg [15:0] outSh_reg;
  reg [4:0]  outCnt_reg;    // Bits still to go out.
  reg        ldEn;
  reg [7:0]  ldRaw;
  reg        ldWhite;
  reg [2:0]  tPost;         // State after the last checksum or data byte.
  wire       canLoad = (outCnt_reg == 5'h00);
  wire [49:0] txSelCfg = crcCfg(coding_reg[`PCIC_SEL_MSB:0]);  // Checksum set-up to latch.
  wire [16:0] txWh = whiten(ldRaw, tLfsr_reg);
  wire [7:0] txByte = ldWhite ? txWh[7:0] : ldRaw;
  wire [18:0] txEnc = encode(txByte, tEnc_reg);
  assign txReady = (tState_reg == T_DATA) & canLoad;
  assign txActive = (tState_reg != T_IDLE);
  assign txBusy = txActive;

  // Picks the byte to load: framer data, checksum, filler or terminator.
  always @* begin
    ldEn = 1'b0;
    ldRaw = 8'h00;
    ldWhite = tWhit_reg;
    tPost = tFec_reg ? (tOdd_reg ? T_TERM : T_PAD) : T_DRAIN;
    case (tState_reg)
      T_DATA: begin
        ldEn = txValid & canLoad;
        ldRaw = txData;
      end
      T_CRC: begin
        ldEn = canLoad;
        ldRaw = tCrc_reg[(5'd23 - {tCrcIdx_reg, 3'b000}) -: 8];
      end
      T_PAD: ldEn = canLoad;
      T_TERM: begin
        ldEn = canLoad;
        ldWhite = 1'b0;  // Zero input flushes the encoder memory.
      end
      default: ;
    endcase
  end

  // Transmit sequencer and output shifter. Loads only happen when the
  // shifter is empty, so a load never collides with a symbol tick.
  always @(posedge clk) begin
    if (reset) begin
      tState_reg <= T_IDLE;
      tFec_reg <= 1'b0;
      tWhit_reg <= 1'b0;
      tCfg_reg <= 50'h0;
      tLfsr_reg <= `PCIC_LFSR_INIT;
      tCrc_reg <= 24'h0;
      tEnc_reg <= 3'h0;
      tOdd_reg <= 1'b0;
      tCrcIdx_reg <= 2'h0;
      outSh_reg <= 16'h0;
      outCnt_reg <= 5'h00;
      txBit <= 1'b0;
      txBitValid <= 1'b0;
      txDone <= 1'b0;
    end else begin
      txBitValid <= 1'b0;
      txDone <= 1'b0;
      if (tState_reg == T_IDLE) begin
        if (txStart) begin
          tState_reg <= T_DATA;
          tFec_reg <= coding_reg[`PCIC_FEC_BIT];
          tWhit_reg <= coding_reg[`PCIC_WHIT_BIT];
          tCfg_reg <= txSelCfg;
          tCrc_reg <= txSelCfg[25:2];
          tLfsr_reg <= `PCIC_LFSR_INIT;
          tEnc_reg <= 3'h0;
          tOdd_reg <= 1'b0;
          tCrcIdx_reg <= 2'h0;
        end
      end else if (ldEn) begin
        if (ldWhite) tLfsr_reg <= txWh[16:8];
        tOdd_reg <= ~tOdd_reg;
        if (tFec_reg) begin
          outSh_reg <= txEnc[15:0];
          outCnt_reg <= 5'h10;
          tEnc_reg <= txEnc[18:16];
        end else begin
          outSh_reg <= {txByte, 8'h00};
          outCnt_reg <= 5'h08;
        end
        case (tState_reg)
          T_DATA: begin
            tCrc_reg <= crcByte(tCrc_reg, txData, tCfg_reg[49:26]);
            if (txLast) tState_reg <= (tCfg_reg[1:0] != 2'h0) ? T_CRC : tPost;
          end
          T_CRC: begin
            tCrcIdx_reg <= tCrcIdx_reg + 2'h1;
            if (tCrcIdx_reg + 2'h1 == tCfg_reg[1:0]) tState_reg <= tPost;
          end
          T_PAD: tState_reg <= T_TERM;
          default: tState_reg <= T_DRAIN;
        endcase
      end else if (tState_reg == T_DRAIN && canLoad) begin
        tState_reg <= T_IDLE;
        txDone <= 1'b1;
      end
      // One on-air bit per tick, coded or not, at the configured rate.
      if (symbolTick && !canLoad) begin
        txBit <= outSh_reg[15];
        txBitValid <= 1'b1;
        outSh_reg <= {outSh_reg[14:0], 1'b0};
        outCnt_reg <= outCnt_reg - 5'h01;
      end
    end
  end

  // Receive side.
  reg                rxAct_reg;
  reg                rxFec_reg;
  reg                rxWhit_reg;
  reg [49:0]         rCfg_reg;
  reg [8:0]          rxLfsr_reg;
  reg [23:0]         rxCrc_reg;
  reg                rxErr_reg;
  reg [16:0]         rxIdx_reg;     // Decoded bytes so far.
  reg [16:0]         rxTotal_reg;   // Bytes to decode, checksum and filler included.
  reg [15:0]         rxNum_reg;     // Framer bytes.
  reg [3:0]          rxK_reg;       // Samples in the de-interleave matrix.
  reg [16*SOFT_W-1:0] mat_reg;
  reg [16*SOFT_W-1:0] work_reg;
  reg [3:0]          vStep_reg;     // Pairs left to decode from work.
  reg [3:0]          vFill_reg;     // Steps decoded, saturating.
  reg [8*PMW-1:0]    pm_reg;
  reg [63:0]         surv_reg;
  reg [7:0]          rxSh_reg;
  reg [2:0]          rxBits_reg;
  assign rxActive = rxAct_reg;

  // Soft pair for this step, read along rows of the matrix.
  wire [2:0] vPair = 3'h7 - vStep_reg[2:0] + 3'h1;
  wire [SOFT_W-1:0] va = work_reg[{vPair, 1'b0} * SOFT_W +: SOFT_W];
  wire [SOFT_W-1:0] vb = work_reg[{vPair, 1'b1} * SOFT_W +: SOFT_W];

  // Add-compare-select with register exchange, then normalisation.
  reg [8*PMW-1:0] pm_next;
  reg [63:0]      surv_next;
  reg [PMW-1:0]   c0;
  reg [PMW-1:0]   c1;
  reg [PMW-1:0]   pmMin;
  reg [2:0]       best;
  integer n;
  always @* begin
    pm_next = pm_reg;
    surv_next = surv_reg;
    pmMin = {PMW{1'b1}};
    best = 3'h0;
    c0 = {PMW{1'b0}};
    c1 = {PMW{1'b0}};
    for (n = 0; n < 8; n = n + 1) begin
      c0 = pm_reg[{n[1:0], 1'b0} * PMW +: PMW] +
           branch({n[1:0], 1'b0}, n[2], va, vb);
      c1 = pm_reg[{n[1:0], 1'b1} * PMW +: PMW] +
           branch({n[1:0], 1'b1}, n[2], va, vb);
      pm_next[n*PMW +: PMW] = (c1 < c0) ? c1 : c0;
      surv_next[n*8 +: 8] = (c1 < c0) ? {surv_reg[{n[1:0], 1'b1}*8 +: 7], n[2]}
                                      : {surv_reg[{n[1:0], 1'b0}*8 +: 7], n[2]};
      if (pm_next[n*PMW +: PMW] < pmMin) begin
        pmMin = pm_next[n*PMW +: PMW];
        best = n[2:0];
      end
    end
    // Keeping the minimum at zero stops the metrics from wrapping.
    for (n = 0; n < 8; n = n + 1) pm_next[n*PMW +: PMW] = pm_next[n*PMW +: PMW] - pmMin;
  end

  // Decoded bit stream: Viterbi output under coding, hard decision otherwise.
  wire decValid = rxAct_reg & (rxFec_reg ? (vStep_reg != 4'h0 &&
                  vFill_reg >= `PCIC_VIT_DEPTH - 1) : rxSoftValid);
  wire decBit = rxFec_reg ? surv_next[best*8 + `PCIC_VIT_DEPTH - 1] : rxSoft[SOFT_W-1];
  wire [7:0] rxRaw = {rxSh_reg[6:0], decBit};
  wire [16:0] rxWh = whiten(rxRaw, rxLfsr_reg);
  wire [7:0] rxClear = rxWhit_reg ? rxWh[7:0] : rxRaw;
  wire [16:0] rxCrcEnd = {1'b0, rxNum_reg} + {15'h0, rCfg_reg[1:0]};
  wire [1:0] rxCrcIdx = rxIdx_reg[1:0] - rxNum_reg[1:0];
  wire rxMiss = (rxClear != rxCrc_reg[(5'd23 - {rxCrcIdx, 3'b000}) -: 8]);
  wire [49:0] rxSelCfg = crcCfg(coding_reg[`PCIC_SEL_MSB:0]);
  wire [16:0] rxLenCrc = {1'b0, rxLength} + {15'h0, rxSelCfg[1:0]};

  // Receive sequencer: matrix fill, decode, byte assembly and check.
  always @(posedge clk) begin
    if (reset) begin
      rxAct_reg <= 1'b0;
      rxFec_reg <= 1'b0;
      rxWhit_reg <= 1'b0;
      rCfg_reg <= 50'h0;
      rxLfsr_reg <= `PCIC_LFSR_INIT;
      rxCrc_reg <= 24'h0;
      rxErr_reg <= 1'b0;
      rxIdx_reg <= 17'h0;
      rxTotal_reg <= 17'h0;
      rxNum_reg <= 16'h0;
      rxK_reg <= 4'h0;
      mat_reg <= {16*SOFT_W{1'b0}};
      work_reg <= {16*SOFT_W{1'b0}};
      vStep_reg <= 4'h0;
      vFill_reg <= 4'h0;
      pm_reg <= {8*PMW{1'b0}};
      surv_reg <= 64'h0;
      rxSh_reg <= 8'h00;
      rxBits_reg <= 3'h0;
      rxOk_reg <= 1'b0;
      rxData <= 8'h00;
      rxDataValid <= 1'b0;
      rxDone <= 1'b0;
      rxCrcOk <= 1'b0;
    end else begin
      rxDataValid <= 1'b0;
      rxDone <= 1'b0;
      if (rxStart) begin
        rxAct_reg <= 1'b1;
        rxFec_reg <= coding_reg[`PCIC_FEC_BIT];
        rxWhit_reg <= coding_reg[`PCIC_WHIT_BIT];
        rCfg_reg <= rxSelCfg;
        rxCrc_reg <= rxSelCfg[25:2];
        rxLfsr_reg <= `PCIC_LFSR_INIT;
        rxErr_reg <= 1'b0;
        rxIdx_reg <= 17'h0;
        rxNum_reg <= rxLength;
        // Filler byte only exists under coding with an odd count.
        rxTotal_reg <= rxLenCrc + {16'h0, coding_reg[`PCIC_FEC_BIT] & rxLenCrc[0]};
        rxK_reg <= 4'h0;
        vStep_reg <= 4'h0;
        vFill_reg <= 4'h0;
        pm_reg <= {{7{PM_FAR}}, {PMW{1'b0}}};  // Encoder starts in state zero.
        rxBits_reg <= 3'h0;
      end else if (rxAct_reg) begin
        // Samples land column by column: sample k goes to row k%4, col k/4.
        if (rxFec_reg && rxSoftValid) begin
          mat_reg[{rxK_reg[1:0], rxK_reg[3:2]} * SOFT_W +: SOFT_W] <= rxSoft;
          rxK_reg <= rxK_reg + 4'h1;
          if (rxK_reg == 4'hf) begin
            // The last sample is merged here so the copy is complete.
            work_reg <= mat_reg;
            work_reg[15*SOFT_W +: SOFT_W] <= rxSoft;
            vStep_reg <= 4'h8;
          end
        end
        if (vStep_reg != 4'h0) begin
          pm_reg <= pm_next;
          surv_reg <= surv_next;
          vStep_reg <= vStep_reg - 4'h1;
          if (vFill_reg != 4'h8) vFill_reg <= vFill_reg + 4'h1;
        end
        if (decValid) begin
          rxSh_reg <= rxRaw;
          rxBits_reg <= rxBits_reg + 3'h1;
          if (rxBits_reg == 3'h7) begin
            if (rxWhit_reg) rxLfsr_reg <= rxWh[16:8];
            rxIdx_reg <= rxIdx_reg + 17'h1;
            if (rxIdx_reg < {1'b0, rxNum_reg}) begin
              rxData <= rxClear;
              rxDataValid <= 1'b1;
              rxCrc_reg <= crcByte(rxCrc_reg, rxClear, rCfg_reg[49:26]);
            end else if (rxIdx_reg < rxCrcEnd && rxMiss) begin
              rxErr_reg <= 1'b1;
            end
            // Filler byte falls through here and is dropped.
            if (rxIdx_reg + 17'h1 == rxTotal_reg) begin
              rxAct_reg <= 1'b0;
              rxDone <= 1'b1;
              rxCrcOk <= ~rxErr_reg & ~(rxIdx_reg < rxCrcEnd &&
                         rxIdx_reg >= {1'b0, rxNum_reg} && rxMiss);
              rxOk_reg <= ~rxErr_reg & ~(rxIdx_reg < rxCrcEnd &&
                          rxIdx_reg >= {1'b0, rxNum_reg} && rxMiss);
            end
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

/* verification/pcic_props.sv */
// Checker on the ports of the coding chain top module.
// Assumes the chain runs at its default clock rate.
`timescale 1ns/1ns
`default_nettype none
module pcic_props (
  input wire logic       clk,
  input wire logic       reset,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic [7:0] paddr,
  input wire logic       pslverr,
  input wire logic       symbolTick,
  input wire logic [8:0] chanFilterScale,
  input wire logic       txStart,
  input wire logic       txReady,
  input wire logic       txBitValid,
  input wire logic       txBusy,
  input wire logic       txDone,
  input wire logic       rxDone
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // Each tick is followed by at least eight clocks without a tick.
  property p_tickGap; symbolTick |=> !symbolTick [*8]; endproperty
  a_tickGap: assert property (p_tickGap) else $error("ticks too close");
  property p_bitOnTick; txBitValid |-> $past(symbolTick); endproperty
  a_bitOnTick: assert property (p_bitOnTick) else $error("bit off tick");
  property p_scale; chanFilterScale == 9'd246; endproperty
  a_scale: assert property (p_scale) else $error("filter scale wrong");
  property p_start; txStart && !txBusy |=> txBusy; endproperty
  a_start: assert property (p_start) else $error("start not taken");
  property p_doneIdle; txDone |=> !txBusy; endproperty
  a_doneIdle: assert property (p_doneIdle) else $error("busy after done");
  property p_readyBusy; txReady |-> txBusy; endproperty
  a_readyBusy: assert property (p_readyBusy) else $error("ready while idle");
  property p_idleQuiet; !txBusy && !txDone |-> !txBitValid; endproperty
  a_idleQuiet: assert property (p_idleQuiet) else $error("bit while idle");
  property p_rxPulse; rxDone |=> !rxDone; endproperty
  a_rxPulse: assert property (p_rxPulse) else $error("done not a pulse");
  property p_slvErr; psel && penable && paddr > 8'h10 |-> pslverr; endproperty
  a_slvErr: assert property (p_slvErr) else $error("unmapped not refused");
endmodule
bind pcic_chain pcic_props pcic_props_i (.clk, .reset, .psel, .penable, .paddr, .pslverr,
  .symbolTick, .chanFilterScale, .txStart, .txReady, .txBitValid, .txBusy, .txDone, .rxDone);
`default_nettype wire

/* verification/pcic_modem.sv */
// Modem model: loops each transmitted bit back as a hard soft sample.
// Assumes bits arrive one per symbol tick, far enough apart for decoding.
`timescale 1ns/1ns
`default_nettype none
module pcic_modem (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       txBit,
  input  wire logic       txBitValid,
  input  wire logic       txBusy,
  input  var  int         errAt,
  output var  logic [2:0] rxSoft,
  output var  logic       rxSoftValid
);
  int cnt;  // Bit index in the current packet.
  // One bit may be flipped on command; outside samples the line toggles.
  always @(posedge clk) begin
    rxSoftValid <= txBitValid;
    if (reset || !txBusy) cnt <= 0;
    else if (txBitValid) cnt <= cnt + 1;
    if (reset) rxSoft <= 3'h0;
    else if (txBitValid) rxSoft <= {3{txBit ^ (cnt == errAt)}};
    else rxSoft <= ~rxSoft;
  end
endmodule
`default_nettype wire

/* verification/tb_pcic_chain.sv */
// Bench for the coding chain: APB set-up, looped-back packets, on-air checks.
// Assumes the modem model closes the loop from the transmitter to the receiver.
`timescale 1ns/1ns
`default_nettype none
module tb_pcic_chain;
  logic clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, se;
  logic [7:0] paddr = 0, txData = 0, rxData;
  logic [31:0] pwdata = 0, prdata, rd;
  logic symbolTick, txReady, txBit, txBitValid, txBusy, txDone, rxSoftValid;
  logic rxDataValid, rxDone, rxCrcOk, txStart = 0, txValid = 0, txLast = 0, rxStart = 0;
  logic [3:0] cfM, cfE;
  logic [8:0] cfS;
  logic [15:0] rxLength = 0;
  logic [2:0] rxSoft;
  logic [7:0] rxBuf [0:15];
  logic airBit [0:511];
  int errTotal = 0, nCompared = 0, cyc = 0, nRx = 0, nAir = 0, lastTick = 0, gap = 0;
  int errAt = -1;
  pcic_chain pcic_chain_i (.clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .symbolTick, .chanFilterMantissa(cfM), .chanFilterExponent(cfE),
    .chanFilterScale(cfS), .txStart, .txData, .txValid, .txLast, .txReady, .txBit,
    .txBitValid, .txBusy, .txDone, .rxStart, .rxLength, .rxSoft, .rxSoftValid, .rxData,
    .rxDataValid, .rxDone, .rxCrcOk);
  pcic_modem pcic_modem_i (.clk, .reset, .txBit, .txBitValid, .txBusy, .errAt, .rxSoft,
    .rxSoftValid);
  initial forever #20 clk = ~clk;
  // Collects on-air bits, received bytes and the tick spacing; cuts a hang short.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (symbolTick) begin
      gap <= cyc - lastTick;
      lastTick <= cyc;
    end
    if (txBitValid) begin
      airBit[nAir] <= txBit;
      nAir <= nAir + 1;
    end
    if (rxDataValid) begin
      rxBuf[nRx] <= rxData;
      nRx <= nRx + 1;
    end
    if (cyc == 60000) begin
      errTotal++;
      conclude;
    end
  end
  task conclude;
    if (errTotal == 0 && nCompared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    nCompared++;
    if (s !== e) begin
      errTotal++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // One APB transfer, entered just after an edge; holds until pready is seen.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    se = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge clk);
  endtask
  function automatic [7:0] dat(input int k);
    dat = 8'h0a + 8'h35 * k[7:0];
  endfunction
  // Bitwise checksum over the three data bytes, preset to ones, MSB first.
  function automatic [23:0] crcOf(input int sel);
    logic [23:0] p, c;
    logic [7:0] d;
    int w, i, b;
    logic fb;
    w = sel == 1 ? 8 : sel == 4 ? 24 : 16;
    p = sel == 1 ? 24'h07 : sel == 2 ? 24'h8005 : sel == 3 ? 24'h1021 : 24'h864cfb;
    c = 24'hffffff >> (24 - w);
    for (i = 0; i < 3; i++) for (b = 7; b >= 0; b--) begin
      d = dat(i) >> b;
      fb = c[w-1] ^ d[0];
      c = (c << 1) & (24'hffffff >> (24 - w));
      if (fb) c = c ^ p;
    end
    return c;
  endfunction
  // Sends three bytes with the given coding set-up and checks both ends.
  task run(input int sel, input int f, input int w, input int ea);
    int c, tot, k;
    logic [23:0] cr, e;
    logic [8:0] l;
    c = sel == 0 ? 0 : sel == 1 ? 1 : sel == 4 ? 3 : 2;
    apb(1, 8'h0c, {27'h0, w[0], f[0], sel[2:0]});
    errAt = ea;
    nRx = 0;
    nAir = 0;
    txStart <= 1;
    rxStart <= 1;
    rxLength <= 16'd3;
    @(posedge clk);
    txStart <= 0;
    rxStart <= 0;
    for (k = 0; k < 3; k++) begin
      txData <= dat(k);
      txValid <= 1;
      txLast <= (k == 2);
      do @(posedge clk); while (txReady !== 1'b1);
    end
    txValid <= 0;
    txLast <= 0;
    k = 0;
    while (rxDone !== 1'b1 && k < 20000) begin
      @(posedge clk);
      k++;
    end
    if (k >= 20000) errTotal++;
    chk(rxCrcOk, ea < 0 || f != 0);
    @(posedge clk);
    tot = 3 + c;
    chk(nAir, f ? 16 * (tot + tot % 2 + 1) : 8 * tot);
    chk(nRx, 3);
    if (ea < 0 || f) for (k = 0; k < 3; k++) chk(rxBuf[k], dat(k));
    if (!f) begin
      cr = crcOf(sel);
      l = 9'h1ff;
      for (k = 0; k < 8 * tot; k++) begin
        e = k < 24 ? dat(k / 8) >> (7 - k % 8) : cr >> (8 * c - 1 - (k - 24));
        chk(airBit[k], e[0] ^ (w[0] & l[0]));
        l = {l[0] ^ l[5], l[8:1]};
      end
    end
  endtask
  initial begin
    repeat (8) @(posedge clk);
    reset <= 0;
    @(posedge clk);
    apb(0, 8'h0c, 0);
    chk(rd, 32'h10);
    apb(0, 8'h14, 0);
    chk({rd[30:0], se}, 32'h1);
    apb(1, 8'h04, 32'hf);
    apb(1, 8'h08, 32'h39);
    chk({cfM, cfE, cfS}, {4'h3, 4'h9, 9'd246});
    run(0, 0, 0, -1);
    run(1, 1, 0, 5);
    run(2, 0, 0, -1);
    run(3, 1, 1, -1);
    run(4, 0, 0, -1);
    run(1, 0, 0, 3);
    run(2, 0, 1, -1);
    chk(gap, 32);
    apb(1, 8'h00, 32'hab);
    apb(0, 8'h00, 0);
    chk(rd, 32'hab);
    apb(0, 8'h04, 0);
    chk(rd, 32'hf);
    conclude;
  end
endmodule
`default_nettype wire
